/* design/dpph_defs.vh */
// Overview of operation
// R1: Port select low picks A, high B
// R2: Control select high on write means command
// R3: Accesses only while chip enable is low
// R4: Read cycle drives addressed port data out
// R5: Write cycle captures data or control byte
// R6: Acknowledge places highest requester's vector
// R7: Bare opcode fetch cycle resets after release
// R8: Chain out high unless this device serviced
// R9: Open-drain interrupt request while requesting
// R10: Output mode strobe rising edge acknowledges
// R11: Input mode latches pins while strobe low
// R12: Bidirectional drives port A only strobe low
// R13: Control mode ignores strobe, ready low
// R14: Output mode ready high once data loaded
// R15: Input mode ready high while register empty
// R16: Bidirectional A uses B strobe and ready
// R17: Reset masks all, disables, clears outputs
// R18: Reset tristates, ready low, input mode
// R19: Reset keeps interrupt vectors
// R20: Reset state held until control word
// R21: Control word bit 0 low loads vector
// R22: Vector returned as loaded, bit 0 zero
// R23: Port A outranks port B internally
// R24: Return opcode on bus ends service
// R25: Low nibble all ones sets mode
// R26: Inputs sampled; commands only when selected
`ifndef DPPH_DEFS_VH
`define DPPH_DEFS_VH
// Operating modes
`define DPPH_MODE_OUT 2'h0
`define DPPH_MODE_IN 2'h1
`define DPPH_MODE_BIDIR 2'h2
`define DPPH_MODE_CTRL 2'h3
// Control word decode
`define DPPH_CW_MODE 4'hF
`define DPPH_CW_INTCTL 4'h7
`define DPPH_CW_IE_BIT 7
`define DPPH_CW_AND_BIT 6
`define DPPH_CW_HIGH_BIT 5
`define DPPH_CW_MASKF_BIT 4
// Reset values
`define DPPH_MASK_RST 8'hFF
`define DPPH_OUT_RST 8'h00
// Return-from-interrupt opcode pair
`define DPPH_RETURN_FROM_IRQ_OPCODE_B0 8'hED
`define DPPH_RETURN_FROM_IRQ_OPCODE_B1 8'h4D
// Write FIFO shape
`define DPPH_FIFO_W 8
`define DPPH_FIFO_D 32
`define DPPH_FIFO_AW 5
`endif

/* design/dpph_edge.v */
`timescale 1ns/1ns
`default_nettype none
// Strobe conditioner: registered level and rising-edge pulse
module dpph_edge
(
	// Clock and reset
	input wire clk,
	input wire reset,
	// Strobe in, active low
	input wire strobe_n,
	// Conditioned outputs
	output reg low,
	output wire rise
);
	// Previous low state
	reg low_d;

	// Register level; idle strobe is high
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			low <= 1'b0;
			low_d <= 1'b0;
		end
		else
		begin
			low <= ~strobe_n;
			low_d <= low;
		end
	end

	// Low to high transition of the pin
	assign rise = low_d & ~low;
endmodule
`default_nettype wire

/* design/dpph_fifo.v */
`timescale 1ns/1ns
`default_nettype none
// Synchronous FIFO, valid/ready on both sides
module dpph_fifo
#(
	parameter W = 8,
	parameter D = 32,
	parameter AW = 5
)
(
	// Clock and reset
	input wire clk,
	input wire reset,
	input wire flush,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	// Storage and pointers
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;

	assign in_ready = (cnt != D[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data = mem[rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage write; no reset needed on data
	always @(posedge clk)
	begin
		if (push)
			mem[wp] <= in_data;
	end

	// Pointers wrap since depth is a power of two
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			if (push & ~pop)
				cnt <= cnt + 1'b1;
			else if (pop & ~push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* design/dpph_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "dpph_defs.vh"
// Two-port parallel handshake device
module dpph_top
(
	// Clock and reset
	input wire clk,
	input wire reset,
	// Processor bus controls
	input wire chip_enable_n,
	input wire port_select,
	input wire ctrl_select,
	input wire io_request_n,
	input wire read_n,
	input wire opcode_fetch_cycle_n,
	// Processor data bus, three signals
	input wire [7:0] cpu_data_in,
	output reg [7:0] cpu_data_out,
	output reg cpu_data_oe_n,
	// Interrupt daisy chain
	input wire priority_chain_in,
	output reg priority_chain_out,
	output reg int_req_out,
	output reg int_req_oe_n,
	// Port A pins
	input wire [7:0] port_a_in,
	output reg [7:0] port_a_out,
	output reg [7:0] port_a_oe_n,
	input wire port_a_strobe_n,
	output reg port_a_ready,
	// Port B pins
	input wire [7:0] port_b_in,
	output reg [7:0] port_b_out,
	output reg [7:0] port_b_oe_n,
	input wire port_b_strobe_n,
	output reg port_b_ready,
	// Port A write FIFO space
	output reg port_a_wr_ready
);
	// Sampled bus inputs
	reg s_ce_n, s_sel, s_cd, s_io_request_n_n, s_rd_n, s_m1_n, s_iei;
	reg [7:0] s_d;
	// Previous-cycle qualifiers
	reg wr_d, rd_d, ack_d, fetch_d, m1_d;
	reg [7:0] d_d;
	// Opcode fetch reset tracking
	reg m1_seen_io;
	reg last_ed;
	// Held in reset until a control word
	reg hold;
	// Cycle qualifiers
	wire acc_wr, acc_rd, acc_ack, fetch;
	wire wr_go, rd_go, ack_go, srst, return_from_irq_opcode_go;
	// Per-port flattened state
	wire [1:0] stb_low, stb_rise;
	wire [3:0] mode_w;
	wire [1:0] ireq, svc_w, rdy_o_w, rdy_i_w, grant;
	wire [15:0] rval_w, out_w, io_w, vec_w;
	wire [7:0] pin_w [0:1];
	wire a_bidir;
	// FIFO hookup
	wire f_in_ready, f_out_valid, f_pop;
	wire [7:0] f_q;

	assign pin_w[0] = port_a_in;
	assign pin_w[1] = port_b_in;

	// Register every processor input on the clock [R26]
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_ce_n <= 1'b1;
			s_sel <= 1'b0;
			s_cd <= 1'b0;
			s_io_request_n_n <= 1'b1;
			s_rd_n <= 1'b1;
			s_m1_n <= 1'b1;
			s_iei <= 1'b0;
			s_d <= 8'h00;
		end
		else
		begin
			s_ce_n <= chip_enable_n;
			s_sel <= port_select;
			s_cd <= ctrl_select;
			s_io_request_n_n <= io_request_n;
			s_rd_n <= read_n;
			s_m1_n <= opcode_fetch_cycle_n;
			s_iei <= priority_chain_in;
			s_d <= cpu_data_in;
		end
	end

	// Access kinds; reads and writes need chip enable, acknowledge does not [R3]
	assign acc_wr = ~s_ce_n & ~s_io_request_n_n & s_rd_n & s_m1_n; // [R5]
	assign acc_rd = ~s_ce_n & ~s_io_request_n_n & ~s_rd_n & s_m1_n; // [R4]
	assign acc_ack = ~s_io_request_n_n & ~s_m1_n; // [R6]
	assign fetch = ~s_m1_n & ~s_rd_n & s_io_request_n_n;
	// One action per cycle, on its first sampled cycle
	assign wr_go = acc_wr & ~wr_d;
	assign rd_go = acc_rd & ~rd_d;
	assign ack_go = acc_ack & ~ack_d;
	// Bare fetch cycle: reset as it ends [R7]
	assign srst = s_m1_n & ~m1_d & ~m1_seen_io;
	// Second opcode byte closes the return sequence [R24]
	assign return_from_irq_opcode_go = fetch_d & ~fetch & last_ed & (d_d == `DPPH_RETURN_FROM_IRQ_OPCODE_B1);

	// Cycle history and return opcode watch
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_d <= 1'b0;
			rd_d <= 1'b0;
			ack_d <= 1'b0;
			fetch_d <= 1'b0;
			m1_d <= 1'b1;
			d_d <= 8'h00;
			m1_seen_io <= 1'b0;
			last_ed <= 1'b0;
		end
		else
		begin
			wr_d <= acc_wr;
			rd_d <= acc_rd;
			ack_d <= acc_ack;
			fetch_d <= fetch;
			m1_d <= s_m1_n;
			d_d <= s_d;
			// Any read or request during the cycle spares reset
			if (s_m1_n)
				m1_seen_io <= 1'b0;
			else if (~s_rd_n | ~s_io_request_n_n)
				m1_seen_io <= 1'b1;
			// Byte is sampled at the fetch's last cycle
			if (fetch_d & ~fetch)
				last_ed <= (d_d == `DPPH_RETURN_FROM_IRQ_OPCODE_B0);
		end
	end

	// Reset state latch; power-up also enters it [R20]
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			hold <= 1'b1;
		else if (srst)
			hold <= 1'b1;
		else if (wr_go & s_cd)
			hold <= 1'b0;
	end

	assign a_bidir = (mode_w[1:0] == `DPPH_MODE_BIDIR);

	// Port A data writes queue here; full refuses the write
	dpph_fifo #(.W(`DPPH_FIFO_W), .D(`DPPH_FIFO_D), .AW(`DPPH_FIFO_AW)) u_fifo
	(
		.clk(clk),
		.reset(reset),
		.flush(srst),
		.in_valid(wr_go & ~s_sel & ~s_cd),
		.in_ready(f_in_ready),
		.in_data(s_d),
		.out_valid(f_out_valid),
		.out_ready(f_pop),
		.out_data(f_q)
	);

	// Per-port logic
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1)
		begin : g_port
			reg [1:0] mode;
			reg ie, and_f, high_f, exp_mask, exp_io;
			reg [7:0] mask, io, outr, inr;
			reg [6:0] vec;
			reg rdy_o, rdy_i, pend, svc, match_d;
			wire me, cw, dw, ld, in_low, in_rise;
			wire [7:0] ldv, act;
			wire m_or, m_and, match;
			// Port owns the access when select matches [R1]
			assign me = (s_sel == p);
			// Command or data by control select [R2]
			assign cw = wr_go & me & s_cd;
			assign dw = wr_go & me & ~s_cd;
			// Port A pulls from its FIFO only when handshake idle
			if (p == 0)
			begin : g_a
				assign f_pop = f_out_valid & ~hold & ~(rdy_o & mode != `DPPH_MODE_CTRL);
				assign ld = f_pop;
				assign ldv = f_q;
				// Bidirectional input side rides port B strobe [R16]
				assign in_low = a_bidir ? stb_low[1] : stb_low[0];
				assign in_rise = a_bidir ? stb_rise[1] : stb_rise[0];
			end
			else
			begin : g_b
				assign ld = dw;
				assign ldv = s_d;
				// B strobe is lent to A in bidirectional mode [R16]
				assign in_low = stb_low[1] & ~a_bidir;
				assign in_rise = stb_rise[1] & ~a_bidir;
			end
			dpph_edge u_edge
			(
				.clk(clk),
				.reset(reset),
				.strobe_n(p == 0 ? port_a_strobe_n : port_b_strobe_n),
				.low(stb_low[p]),
				.rise(stb_rise[p])
			);
			// Control mode monitor
			assign act = high_f ? pin_w[p] : ~pin_w[p];
			assign m_or = |(act & ~mask);
			assign m_and = (&(act | mask)) & ~(&mask);
			assign match = and_f ? m_and : m_or;

			// Control words, handshake and interrupt state
			always @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					mode <= `DPPH_MODE_IN;
					ie <= 1'b0;
					and_f <= 1'b0;
					high_f <= 1'b0;
					exp_mask <= 1'b0;
					exp_io <= 1'b0;
					mask <= `DPPH_MASK_RST;
					io <= 8'hFF;
					outr <= `DPPH_OUT_RST;
					inr <= 8'h00;
					vec <= 7'h00;
					rdy_o <= 1'b0;
					rdy_i <= 1'b0;
					pend <= 1'b0;
					svc <= 1'b0;
					match_d <= 1'b0;
				end
				else if (srst)
				begin
					// All bits masked, enables and outputs cleared; vector kept [R17] [R19]
					mode <= `DPPH_MODE_IN; // [R18]
					ie <= 1'b0;
					exp_mask <= 1'b0;
					exp_io <= 1'b0;
					mask <= `DPPH_MASK_RST;
					outr <= `DPPH_OUT_RST;
					rdy_o <= 1'b0;
					rdy_i <= 1'b0;
					pend <= 1'b0;
					svc <= 1'b0;
				end
				else
				begin
					match_d <= match;
					if (cw)
					begin
						// Follow-on words take precedence over decode
						if (exp_io)
						begin
							io <= s_d;
							exp_io <= 1'b0;
						end
						else if (exp_mask)
						begin
							mask <= s_d;
							exp_mask <= 1'b0;
						end
						else if (~s_d[0])
							vec <= s_d[7:1]; // [R21]
						else if (s_d[3:0] == `DPPH_CW_MODE)
						begin
							// Port B cannot be bidirectional; falls to input [R25]
							if (p == 1 && s_d[7:6] == `DPPH_MODE_BIDIR)
								mode <= `DPPH_MODE_IN;
							else
								mode <= s_d[7:6];
							exp_io <= (s_d[7:6] == `DPPH_MODE_CTRL);
						end
						else if (s_d[3:0] == `DPPH_CW_INTCTL)
						begin
							ie <= s_d[`DPPH_CW_IE_BIT];
							and_f <= s_d[`DPPH_CW_AND_BIT];
							high_f <= s_d[`DPPH_CW_HIGH_BIT];
							exp_mask <= s_d[`DPPH_CW_MASKF_BIT];
						end
					end
					// Output register load raises ready except in control mode [R14]
					if (ld)
						outr <= ldv;
					if (ld & mode != `DPPH_MODE_CTRL)
						rdy_o <= 1'b1;
					else if (stb_rise[p] & (mode == `DPPH_MODE_OUT | mode == `DPPH_MODE_BIDIR))
						rdy_o <= 1'b0; // [R10] [R12]
					// Input latch transparent while strobe low [R11]
					if (in_low & (mode == `DPPH_MODE_IN | mode == `DPPH_MODE_BIDIR))
						inr <= pin_w[p];
					// Reading the data empties the input register [R15]
					if (rd_go & me & ~s_cd & (mode == `DPPH_MODE_IN | mode == `DPPH_MODE_BIDIR))
						rdy_i <= 1'b1;
					else if (in_rise)
						rdy_i <= 1'b0;
					// Acknowledge moves request to service; new event wins
					if (ack_go & grant[p])
						svc <= 1'b1;
					else if (return_from_irq_opcode_go & s_iei & svc & (p == 0 || ~svc_w[0]))
						svc <= 1'b0; // [R23] [R24]
					if (mode == `DPPH_MODE_CTRL ? (match & ~match_d)
						: ((stb_rise[p] & mode != `DPPH_MODE_IN) | in_rise))
						pend <= 1'b1;
					else if (ack_go & grant[p])
						pend <= 1'b0;
					else if (cw & ~exp_io & ~exp_mask & s_d[0]
						& s_d[3:0] == `DPPH_CW_INTCTL & s_d[`DPPH_CW_MASKF_BIT])
						pend <= 1'b0;
				end
			end

			// Strobe ignored in control mode: no latch, no ready [R13]
			assign mode_w[2*p+1:2*p] = mode;
			assign ireq[p] = ie & pend;
			assign svc_w[p] = svc;
			assign rdy_o_w[p] = rdy_o;
			assign rdy_i_w[p] = rdy_i;
			assign out_w[8*p+7:8*p] = outr;
			assign io_w[8*p+7:8*p] = io;
			assign vec_w[8*p+7:8*p] = {vec, 1'b0}; // [R22]
			// Port A wins when both request [R23]
			assign grant[p] = s_iei & ireq[p] & (p == 0 || ~ireq[0]);
			// Control mode mixes pins and output register
			assign rval_w[8*p+7:8*p] = (mode == `DPPH_MODE_CTRL) ?
				((pin_w[p] & io) | (outr & ~io)) :
				(mode == `DPPH_MODE_OUT) ? outr : inr;
		end
	endgenerate

	// Processor data bus driver
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cpu_data_out <= 8'h00;
			cpu_data_oe_n <= 1'b1;
		end
		else if (acc_ack & ack_d & ~cpu_data_oe_n)
			cpu_data_oe_n <= 1'b0; // Grant drops once in service, so hold vector [R6]
		else if (acc_ack & ~ack_d & (|grant))
		begin
			// Vector of highest requester, chosen on the first cycle [R6] [R22]
			cpu_data_out <= grant[0] ? vec_w[7:0] : vec_w[15:8];
			cpu_data_oe_n <= 1'b0;
		end
		else if (acc_rd)
		begin
			cpu_data_out <= s_sel ? rval_w[15:8] : rval_w[7:0]; // [R1] [R4]
			cpu_data_oe_n <= 1'b0;
		end
		else
			cpu_data_oe_n <= 1'b1; // [R3]
	end

	// Chain, interrupt request and FIFO space
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			priority_chain_out <= 1'b0;
			int_req_out <= 1'b0;
			int_req_oe_n <= 1'b1;
			port_a_wr_ready <= 1'b0;
		end
		else
		begin
			priority_chain_out <= s_iei & ~(|svc_w); // [R8]
			// Open drain: pull low only while requesting [R9]
			int_req_out <= 1'b0;
			int_req_oe_n <= ~(s_iei & ((ireq[0] & ~svc_w[0])
				| (ireq[1] & ~svc_w[0] & ~svc_w[1])));
			port_a_wr_ready <= f_in_ready;
		end
	end

	// Port pins and ready lines; reset state idles them [R18]
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			port_a_out <= 8'h00;
			port_b_out <= 8'h00;
			port_a_oe_n <= 8'hFF;
			port_b_oe_n <= 8'hFF;
			port_a_ready <= 1'b0;
			port_b_ready <= 1'b0;
		end
		else
		begin
			port_a_out <= out_w[7:0];
			port_b_out <= out_w[15:8];
			// Bidirectional drives only under strobe [R12]
			case (mode_w[1:0])
				`DPPH_MODE_OUT: port_a_oe_n <= hold ? 8'hFF : 8'h00;
				`DPPH_MODE_BIDIR: port_a_oe_n <= (~hold & stb_low[0]) ? 8'h00 : 8'hFF;
				`DPPH_MODE_CTRL: port_a_oe_n <= hold ? 8'hFF : io_w[7:0];
				default: port_a_oe_n <= 8'hFF;
			endcase
			case (mode_w[3:2])
				`DPPH_MODE_OUT: port_b_oe_n <= hold ? 8'hFF : 8'h00;
				`DPPH_MODE_CTRL: port_b_oe_n <= hold ? 8'hFF : io_w[15:8];
				default: port_b_oe_n <= 8'hFF;
			endcase
			// Ready forced low in control mode (port B only while A is not bidirectional) and in reset [R13]
			case (mode_w[1:0])
				`DPPH_MODE_OUT: port_a_ready <= ~hold & rdy_o_w[0];
				`DPPH_MODE_IN: port_a_ready <= ~hold & rdy_i_w[0];
				`DPPH_MODE_BIDIR: port_a_ready <= ~hold & rdy_o_w[0];
				default: port_a_ready <= 1'b0;
			endcase
			if (a_bidir)
				port_b_ready <= ~hold & rdy_i_w[0]; // [R16]
			else
				case (mode_w[3:2])
					`DPPH_MODE_OUT: port_b_ready <= ~hold & rdy_o_w[1];
					`DPPH_MODE_IN: port_b_ready <= ~hold & rdy_i_w[1];
					default: port_b_ready <= 1'b0;
				endcase
		end
	end
endmodule
`default_nettype wire

/* testbench/dpph_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// Pin-level checks on the two-port device
module dpph_chk
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Processor side
	input wire logic chip_enable_n,
	input wire logic ctrl_select,
	input wire logic io_request_n,
	input wire logic read_n,
	input wire logic opcode_fetch_cycle_n,
	input wire logic [7:0] cpu_data_out,
	input wire logic cpu_data_oe_n,
	input wire logic priority_chain_in,
	input wire logic priority_chain_out,
	input wire logic int_req_oe_n,
	// Peripheral side
	input wire logic [7:0] port_a_oe_n,
	input wire logic [7:0] port_b_oe_n,
	input wire logic port_a_strobe_n,
	input wire logic port_b_strobe_n,
	input wire logic port_a_ready,
	input wire logic port_b_ready
);
	// Set by the first sampled control write, cleared only by the reset pin
	logic ctl_seen;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ctl_seen <= 1'b0;
		else if (!chip_enable_n && !io_request_n && read_n && ctrl_select)
			ctl_seen <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Held read drives the bus by the fourth sample
	property p_read_drive;
		(!chip_enable_n && !io_request_n && !read_n && opcode_fetch_cycle_n) [*4]
			|-> !cpu_data_oe_n;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");
	// No request for three samples leaves the bus free
	property p_idle_quiet;
		io_request_n [*3] |-> cpu_data_oe_n;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("bus driven idle");
	// Deselected outside acknowledge leaves the bus free
	property p_ce_off;
		(chip_enable_n && opcode_fetch_cycle_n) [*3] |-> cpu_data_oe_n;
	endproperty
	a_ce_off: assert property (p_ce_off) else $error("bus driven deselected");
	// Vector bit 0 reads zero on acknowledge
	property p_ack_vec;
		(!io_request_n && !opcode_fetch_cycle_n) [*4] ##0 !cpu_data_oe_n
			|-> !cpu_data_out[0];
	endproperty
	a_ack_vec: assert property (p_ack_vec) else $error("vector bit 0 set");
	// Chain out follows a low chain in
	property p_chain_off;
		(!priority_chain_in) [*3] |-> !priority_chain_out;
	endproperty
	a_chain_off: assert property (p_chain_off) else $error("chain out high");
	// Nothing in service before any control word
	property p_chain_on;
		(priority_chain_in && !ctl_seen) [*3] |-> priority_chain_out;
	endproperty
	a_chain_on: assert property (p_chain_on) else $error("chain out low");
	// Interrupts start disabled
	property p_no_irq;
		!ctl_seen |-> int_req_oe_n;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("request while disabled");
	// Held reset state until the first control word
	property p_held;
		!ctl_seen |-> port_a_oe_n == 8'hFF && port_b_oe_n == 8'hFF
			&& !port_a_ready && !port_b_ready;
	endproperty
	a_held: assert property (p_held) else $error("reset state left early");
	// Strobe rise ends ready within five cycles
	property p_rdy_a;
		$rose(port_a_strobe_n) |-> ##[1:5] !port_a_ready;
	endproperty
	a_rdy_a: assert property (p_rdy_a) else $error("port A ready stuck");
	property p_rdy_b;
		$rose(port_b_strobe_n) |-> ##[1:5] !port_b_ready;
	endproperty
	a_rdy_b: assert property (p_rdy_b) else $error("port B ready stuck");
	// Main scenarios reached
	c_ack: cover property (!io_request_n && !opcode_fetch_cycle_n && !cpu_data_oe_n);
	c_irq: cover property (!int_req_oe_n);
	c_ack_a: cover property ($rose(port_a_strobe_n) && port_a_ready);
endmodule
`default_nettype wire

/* testbench/dpph_periph.sv */
`timescale 1ns/1ns
`default_nettype none
// Handshaking peripheral on one port
module dpph_periph
(
	// Clock
	input wire logic clk,
	// Behaviour from the bench
	input wire logic en,
	input wire logic slow,
	input wire logic [7:0] tx,
	// Device pins
	input wire logic [7:0] dev_out,
	input wire logic [7:0] dev_oe_n,
	input wire logic ready,
	output logic strobe_n,
	output logic [7:0] pins,
	// Last byte taken and count
	output logic [7:0] last_rx,
	output logic [7:0] rx_cnt
);
	// Bits the device leaves free carry our byte
	assign pins = (dev_out & ~dev_oe_n) | (tx & dev_oe_n);
	// One strobe per ready; gap lets ready fall first
	initial
	begin
		strobe_n = 1'b1;
		last_rx = 8'h00;
		rx_cnt = 8'h00;
		forever
		begin
			@(posedge clk);
			if (en && ready === 1'b1)
			begin
				repeat (slow ? 6 : 1) @(posedge clk);
				#2 strobe_n = 1'b0;
				repeat (slow ? 4 : 2) @(posedge clk);
				#2 strobe_n = 1'b1;
				last_rx = pins;
				rx_cnt = rx_cnt + 8'h01;
				repeat (8) @(posedge clk);
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the two-port device
module tb_top;
	// Clock, reset and processor bus
	logic clk = 1'b0, reset = 1'b1, priority_chain_in = 1'b1;
	logic chip_enable_n = 1'b1, port_select = 1'b0, ctrl_select = 1'b0;
	logic io_request_n = 1'b1, read_n = 1'b1, opcode_fetch_cycle_n = 1'b1;
	logic [7:0] cpu_data_in = 8'h00;
	// Device outputs
	logic [7:0] cpu_data_out, port_a_out, port_a_oe_n, port_b_out, port_b_oe_n;
	logic cpu_data_oe_n, priority_chain_out, int_req_out, int_req_oe_n;
	logic port_a_ready, port_b_ready, port_a_wr_ready;
	// Peripheral pins and controls
	logic [7:0] port_a_in, port_b_in, rx_a, rx_b, cnt_a, cnt_b;
	logic [7:0] tx_a = 8'h00, tx_b = 8'h3C;
	logic port_a_strobe_n, port_b_strobe_n, en_a = 1'b0, en_b = 1'b0, slow = 1'b0;
	int error_cnt = 0, num_checks = 0;
	always #20 clk = ~clk;
	dpph_top i_dut (.clk, .reset, .chip_enable_n, .port_select, .ctrl_select, .io_request_n,
		.read_n, .opcode_fetch_cycle_n, .cpu_data_in, .cpu_data_out, .cpu_data_oe_n,
		.priority_chain_in, .priority_chain_out, .int_req_out, .int_req_oe_n,
		.port_a_in, .port_a_out, .port_a_oe_n, .port_a_strobe_n, .port_a_ready,
		.port_b_in, .port_b_out, .port_b_oe_n, .port_b_strobe_n, .port_b_ready,
		.port_a_wr_ready);
	dpph_periph i_pa (.clk, .en(en_a), .slow, .tx(tx_a), .dev_out(port_a_out),
		.dev_oe_n(port_a_oe_n), .ready(port_a_ready), .strobe_n(port_a_strobe_n),
		.pins(port_a_in), .last_rx(rx_a), .rx_cnt(cnt_a));
	dpph_periph i_pb (.clk, .en(en_b), .slow, .tx(tx_b), .dev_out(port_b_out),
		.dev_oe_n(port_b_oe_n), .ready(port_b_ready), .strobe_n(port_b_strobe_n),
		.pins(port_b_in), .last_rx(rx_b), .rx_cnt(cnt_b));
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Wait edges, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// One bus cycle held four samples; acknowledge when ak is set
	task automatic acc(input logic ak, p, cd, rd, input logic [7:0] d, output logic [7:0] q);
		port_select = p;
		ctrl_select = cd;
		cpu_data_in = d;
		chip_enable_n = ak;
		opcode_fetch_cycle_n = !ak;
		io_request_n = 1'b0;
		read_n = !rd;
		cyc(4);
		q = cpu_data_oe_n === 1'b0 ? cpu_data_out : 8'hXX;
		chip_enable_n = 1'b1;
		opcode_fetch_cycle_n = 1'b1;
		io_request_n = 1'b1;
		read_n = 1'b1;
		cyc(3);
	endtask
	task automatic wr(input logic p, cd, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b0, p, cd, 1'b0, d, q);
	endtask
	task automatic rd(input logic p, input logic [7:0] exp);
		logic [7:0] q;
		acc(1'b0, p, 1'b0, 1'b1, 8'h00, q);
		chk(q, exp);
	endtask
	// Opcode fetch of one byte
	task automatic fetch(input logic [7:0] d);
		cpu_data_in = d;
		opcode_fetch_cycle_n = 1'b0;
		read_n = 1'b0;
		cyc(3);
		opcode_fetch_cycle_n = 1'b1;
		read_n = 1'b1;
		cyc(2);
	endtask
	// Held reset state at the pins
	task automatic t_reset();
		chk({port_a_ready, port_b_ready, int_req_oe_n, cpu_data_oe_n, int_req_out, 3'h0}, 8'h30);
		chk(port_a_oe_n & port_b_oe_n, 8'hFF);
		chk(port_a_out | port_b_out, 8'h00);
	endtask
	// Output mode, FIFO filled until refused then drained by a slow peripheral
	task automatic t_out();
		int n;
		int t;
		wr(1'b0, 1'b1, 8'h0F);
		wr(1'b0, 1'b0, 8'h5A);
		chk(port_a_out, 8'h5A);
		chk({port_a_oe_n[6:0], port_a_ready}, 8'h01);
		rd(1'b0, 8'h5A);
		n = 0;
		while (port_a_wr_ready === 1'b1 && n < 40)
		begin
			wr(1'b0, 1'b0, 8'h80 + n[7:0]);
			n++;
		end
		chk(n[7:0], 8'h20);
		wr(1'b1, 1'b1, 8'h0F);
		wr(1'b1, 1'b0, 8'hA5);
		chk(port_b_out, 8'hA5);
		slow = 1'b1;
		en_a = 1'b1;
		for (int k = 1; k <= 33; k++)
		begin
			t = 0;
			while (cnt_a != k[7:0] && t < 100)
			begin
				cyc(1);
				t++;
			end
			chk(rx_a, k == 1 ? 8'h5A : 8'h7E + k[7:0]);
		end
		en_a = 1'b0;
		cyc(10);
		chk({7'h0, port_a_ready}, 8'h00);
	endtask
	// Input mode interrupt, acknowledge and return on port B
	task automatic t_irq(input logic load_vec);
		int t;
		wr(1'b1, 1'b1, 8'h4F);
		if (load_vec)
			wr(1'b1, 1'b1, 8'hE0);
		wr(1'b1, 1'b1, 8'h87);
		acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, rx_b);
		chk({7'h0, port_b_ready}, 8'h01);
		en_b = 1'b1;
		t = 0;
		while (port_b_strobe_n !== 1'b0 && t < 50)
		begin
			cyc(1);
			t++;
		end
		en_b = 1'b0;
		cyc(12);
		chk({port_b_ready, int_req_oe_n, 6'h0}, 8'h00);
		acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, rx_b);
		chk(rx_b, 8'hE0);
		chk({7'h0, priority_chain_out}, 8'h00);
		fetch(8'hED);
		fetch(8'h4D);
		cyc(2);
		chk({7'h0, priority_chain_out}, 8'h01);
		rd(1'b1, 8'h3C);
		priority_chain_in = 1'b0;
		cyc(3);
		chk({7'h0, priority_chain_out}, 8'h00);
		priority_chain_in = 1'b1;
		cyc(3);
	endtask
	// Bidirectional port A: pins driven only under its strobe, B lines for input
	task automatic t_bidir();
		int t;
		wr(1'b0, 1'b1, 8'h8F);
		wr(1'b0, 1'b0, 8'hC3);
		chk({port_a_oe_n[6:0], port_a_ready}, 8'hFF);
		en_a = 1'b1;
		t = 0;
		while (cnt_a !== 8'h22 && t < 100)
		begin
			cyc(1);
			t++;
		end
		en_a = 1'b0;
		chk(rx_a, 8'hC3);
		tx_a = 8'h96;
		rd(1'b0, 8'h00);
		chk({7'h0, port_b_ready}, 8'h01);
		en_b = 1'b1;
		t = 0;
		while (port_b_strobe_n !== 1'b0 && t < 50)
		begin
			cyc(1);
			t++;
		end
		en_b = 1'b0;
		cyc(12);
		chk({7'h0, port_b_ready}, 8'h00);
		rd(1'b0, 8'h96);
	endtask
	// Control mode with low nibble as inputs
	task automatic t_ctrl();
		wr(1'b0, 1'b1, 8'hCF);
		wr(1'b0, 1'b1, 8'h0F);
		wr(1'b0, 1'b0, 8'hA0);
		chk(port_a_oe_n, 8'h0F);
		chk({port_a_out[7:4], 3'h0, port_a_ready}, 8'hA0);
	endtask
	// Bare opcode fetch cycle puts the device back in reset
	task automatic t_soft();
		opcode_fetch_cycle_n = 1'b0;
		cyc(3);
		opcode_fetch_cycle_n = 1'b1;
		cyc(4);
		t_reset();
	endtask
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		#2 reset = 1'b0;
		cyc(1);
		t_reset();
		t_out();
		t_irq(1'b1);
		t_bidir();
		t_ctrl();
		t_soft();
		t_irq(1'b0);
		print_verdict();
	end
	// Watchdog well beyond the expected run
	initial
	begin
		#800000;
		error_cnt++;
		print_verdict();
	end
endmodule
bind dpph_top dpph_chk i_chk (.clk, .reset, .chip_enable_n, .ctrl_select, .io_request_n,
	.read_n, .opcode_fetch_cycle_n, .cpu_data_out, .cpu_data_oe_n, .priority_chain_in,
	.priority_chain_out, .int_req_oe_n, .port_a_oe_n, .port_b_oe_n, .port_a_strobe_n,
	.port_b_strobe_n, .port_a_ready, .port_b_ready);
`default_nettype wire
